// file: hw/clpm_pkg.sv
`default_nettype none
package clpm_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] CTR_LO_BASE = 8'h00;
	localparam logic [7:0] CTR_HI_BASE = 8'h04;
	localparam logic [7:0] CTR_STRIDE  = 8'h08;
	localparam logic [7:0] CTL_BASE    = 8'h20;
	localparam logic [7:0] CTL_STRIDE  = 8'h04;
	localparam logic [7:0] RATE_ADDR   = 8'h30;
	localparam logic [7:0] IDLE_ADDR   = 8'h34;
	localparam logic [7:0] RETRY_ADDR  = 8'h38;
	localparam int         ADR_MSB     = 7;
	// ------------------------------------------------------------
	// control register fields and reset values
	// ------------------------------------------------------------
	localparam int         EV_LSB      = 0;
	localparam int         EV_MSB      = 7;
	localparam int         UM_LSB      = 8;
	localparam int         UM_MSB      = 15;
	localparam int         EN_BIT      = 22;
	localparam int         CTR_W       = 48;
	localparam int         HI_W        = 16;
	localparam int         INC_W       = 9;
	localparam int         RATE_W      = 3;
	localparam logic [2:0] RATE_RST    = 3'h3;
	localparam logic [31:0] CTL_RST    = 32'h0000_0000;
	// ------------------------------------------------------------
	// event codes
	// ------------------------------------------------------------
	localparam logic [7:0] EV_CLOCK    = 8'h01;
	localparam logic [7:0] EV_TX_HDR   = 8'h04;
	localparam logic [7:0] EV_RX_HDR   = 8'h05;
	localparam logic [7:0] EV_DIRECT   = 8'h12;
	localparam logic [7:0] EV_INIT     = 8'h20;
	localparam logic [7:0] EV_SHUT_CYC = 8'h21;
	localparam logic [7:0] EV_SHUT_ACK = 8'h22;
	localparam logic [7:0] EV_SHUT_NAK = 8'h23;
	localparam logic [7:0] EV_RX_ALLOC = 8'h30;
	localparam logic [7:0] EV_RX_BYP   = 8'h31;
	localparam logic [7:0] EV_RX_OCC   = 8'h32;
	localparam logic [7:0] EV_CRD_BACK = 8'h44;
	// ------------------------------------------------------------
	// physical layer state encoding
	// ------------------------------------------------------------
	localparam logic [2:0] PHY_INIT     = 3'h0;
	localparam logic [2:0] PHY_FULL     = 3'h1;
	localparam logic [2:0] PHY_LOWPWR   = 3'h2;
	localparam logic [2:0] PHY_HALF     = 3'h3;
	localparam logic [2:0] PHY_SHUTDOWN = 3'h4;
endpackage : clpm_pkg
`default_nettype wire

// file: hw/clpm_cnt_if.sv
`default_nettype none
interface clpm_cnt_if;
	logic [8:0]  inc;
	logic        wr_lo;
	logic        wr_hi;
	logic [31:0] wdata;
	logic [47:0] value;
	modport ctrl (output inc, output wr_lo, output wr_hi, output wdata, input value);
	modport cnt  (input inc, input wr_lo, input wr_hi, input wdata, output value);
endinterface : clpm_cnt_if
`default_nettype wire

// file: hw/clpm_counter.sv
`default_nettype none
module clpm_counter (
	input  wire logic clock,
	input  wire logic resetn,
	clpm_cnt_if.cnt   port
);
	logic [47:0] value_reg;
	logic [47:0] value_next;

	// ------------------------------------------------------------
	// 48-bit accumulate with software load of either half
	// ------------------------------------------------------------
	assign value_next = port.wr_lo ? {value_reg[47:32], port.wdata}
		: port.wr_hi ? {port.wdata[15:0], value_reg[31:0]}
		: value_reg + {39'h0, port.inc}; // R3 R20
	assign port.value = value_reg;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			value_reg <= 48'h0;
		else
			value_reg <= value_next;
	end

	AST_WRAP: assert property (@(posedge clock) disable iff (!resetn) // R20
		(value_reg == 48'hFFFF_FFFF_FFFF && port.inc == 9'h001 && !port.wr_lo && !port.wr_hi)
		|=> value_reg == 48'h0)
		else $error("counter did not wrap to zero");
endmodule : clpm_counter
`default_nettype wire

// file: hw/clpm_top.sv
// How it works
// R1: four 48-bit counters, each with control
// R2: any event code valid on any counter
// R3: counter adds up to nine bits per cycle
// R4: rate field bits 2:0, resets to three
// R5: software writes zero to rate reserved bits
// R6: idle counter counts null and shutdown cycles
// R7: retry counter counts receive retry cycles
// R8: free counters writable, hardware updated, reset zero
// R9: code 0x1 counts every clock
// R10: code 0x20 counts initialization cycles; here the unencoded phy states 5-7 count too
// R11: codes 0x21-0x23 shutdown cycles, accepts, refusals
// R12: codes 0x30-0x32 receive buffer events
// R13: code 0x44 accumulates pending shared credits
// R14: codes 0x5/0x4 receive/transmit header matches
// R15: code 0x12 counts direct delivery attempts
// R16: direct attempt unit mask selects outcome
// R17: only caching-agent data responses are candidates
// R18: slot events add zero, one or two; the 2-bit slot counts here can also add three
// R19: one counter never mixes receive and transmit
// R20: counters wrap modulo two to forty-eight
`default_nettype none
module clpm_top #(
	parameter int NUM_CTR = 4
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic      [31:0] wb_dat_o,
	input  wire logic [2:0]  link_rate_code,
	input  wire logic [2:0]  phy_state,
	input  wire logic        rx_idle,
	input  wire logic        rx_retry,
	input  wire logic        shutdown_accept_event,
	input  wire logic        shutdown_refuse_event,
	input  wire logic [1:0]  rx_alloc_cnt,
	input  wire logic [1:0]  rx_bypass_cnt,
	input  wire logic [8:0]  rx_occupancy,
	input  wire logic [8:0]  credit_backlog,
	input  wire logic [1:0]  rx_hdr_match_cnt,
	input  wire logic [1:0]  tx_hdr_match_cnt,
	input  wire logic        drs_valid,
	input  wire logic        drs_to_caching_agent,
	input  wire logic [1:0]  drs_outcome
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[8*b +: 8] = new_v[8*b +: 8];
		return r;
	endfunction : merge_lanes

	function automatic logic [8:0] widen2(input logic [1:0] v);
		return {7'h00, v};
	endfunction : widen2

	// ------------------------------------------------------------
	// event sources
	// ------------------------------------------------------------
	wire logic ev_init_cyc;
	wire logic ev_shut_cyc;
	wire logic drs_candidate;
	assign ev_init_cyc = (phy_state != clpm_pkg::PHY_FULL) && (phy_state != clpm_pkg::PHY_LOWPWR)
		&& (phy_state != clpm_pkg::PHY_HALF) && (phy_state != clpm_pkg::PHY_SHUTDOWN); // R10
	assign ev_shut_cyc   = phy_state == clpm_pkg::PHY_SHUTDOWN; // R11
	assign drs_candidate = drs_valid && drs_to_caching_agent; // R17

	// event inputs reach the decode as an argument, so it re-evaluates whenever any of them moves
	typedef struct packed {
		logic       init_cyc;
		logic       shut_cyc;
		logic       shut_accept;
		logic       shut_refuse;
		logic [1:0] alloc;
		logic [1:0] bypass;
		logic [8:0] occupancy;
		logic [8:0] backlog;
		logic [1:0] rx_hdr;
		logic [1:0] tx_hdr;
		logic       candidate;
		logic [1:0] outcome;
	} clpm_ev_src_t;
	clpm_ev_src_t ev_src;
	assign ev_src = {ev_init_cyc, ev_shut_cyc, shutdown_accept_event, shutdown_refuse_event,
		rx_alloc_cnt, rx_bypass_cnt, rx_occupancy, credit_backlog,
		rx_hdr_match_cnt, tx_hdr_match_cnt, drs_candidate, drs_outcome};

	// one event per selection, so a counter sees either the receive or the transmit path
	function automatic logic [8:0] event_inc(input logic [7:0] code, input logic [7:0] umask,
		input clpm_ev_src_t src);
		logic [8:0] r;
		r = 9'h000;
		case (code)
			clpm_pkg::EV_CLOCK:    r = 9'h001; // R9
			clpm_pkg::EV_INIT:     r = {8'h00, src.init_cyc}; // R10
			clpm_pkg::EV_SHUT_CYC: r = {8'h00, src.shut_cyc}; // R11
			clpm_pkg::EV_SHUT_ACK: r = {8'h00, src.shut_accept}; // R11
			clpm_pkg::EV_SHUT_NAK: r = {8'h00, src.shut_refuse}; // R11
			clpm_pkg::EV_RX_ALLOC: r = widen2(src.alloc); // R12 R18
			clpm_pkg::EV_RX_BYP:   r = widen2(src.bypass); // R12 R18
			clpm_pkg::EV_RX_OCC:   r = src.occupancy; // R12
			clpm_pkg::EV_CRD_BACK: r = src.backlog; // R13
			clpm_pkg::EV_RX_HDR:   r = widen2(src.rx_hdr); // R14 R19
			clpm_pkg::EV_TX_HDR:   r = widen2(src.tx_hdr); // R14 R19
			clpm_pkg::EV_DIRECT:   r = {8'h00, src.candidate && umask[src.outcome]}; // R15 R16 R17
			default:               r = 9'h000;
		endcase
		return r;
	endfunction : event_inc

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire logic        bus_req;
	wire logic        wr_req;
	wire logic [31:0] rd_mux;
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_req  = bus_req && wb_we_i;

	logic [31:0] ctl_reg [NUM_CTR];
	logic [2:0]  rate_reg;
	logic [31:0] idle_reg;
	logic [31:0] idle_next;
	logic [31:0] retry_reg;
	logic [31:0] retry_next;
	logic [31:0] rd_lo [NUM_CTR];
	logic [31:0] rd_hi [NUM_CTR];
	logic [31:0] rd_ctl [NUM_CTR];
	logic [NUM_CTR-1:0] hit_lo;
	logic [NUM_CTR-1:0] hit_hi;
	logic [NUM_CTR-1:0] hit_ctl;
	logic [8:0]  cnt_inc [NUM_CTR];

	wire logic hit_rate;
	wire logic hit_idle;
	wire logic hit_retry;
	assign hit_rate  = wb_adr_i == clpm_pkg::RATE_ADDR;
	assign hit_idle  = wb_adr_i == clpm_pkg::IDLE_ADDR;
	assign hit_retry = wb_adr_i == clpm_pkg::RETRY_ADDR;

	// ------------------------------------------------------------
	// general counters
	// ------------------------------------------------------------
	clpm_cnt_if cif [NUM_CTR] ();

	genvar g;
	generate
		for (g = 0; g < NUM_CTR; g++)
		begin : gen_ctr
			wire logic [7:0] lo_addr;
			wire logic [7:0] hi_addr;
			wire logic [7:0] ctl_addr;
			wire logic       ctr_en;
			assign lo_addr  = 8'(clpm_pkg::CTR_LO_BASE + 8'(g) * clpm_pkg::CTR_STRIDE);
			assign hi_addr  = 8'(clpm_pkg::CTR_HI_BASE + 8'(g) * clpm_pkg::CTR_STRIDE);
			assign ctl_addr = 8'(clpm_pkg::CTL_BASE + 8'(g) * clpm_pkg::CTL_STRIDE);
			assign hit_lo[g]  = wb_adr_i == lo_addr;
			assign hit_hi[g]  = wb_adr_i == hi_addr;
			assign hit_ctl[g] = wb_adr_i == ctl_addr;
			assign ctr_en     = ctl_reg[g][clpm_pkg::EN_BIT];
			// any counter takes any code
			assign cnt_inc[g] = ctr_en ? event_inc(ctl_reg[g][clpm_pkg::EV_MSB:clpm_pkg::EV_LSB],
				ctl_reg[g][clpm_pkg::UM_MSB:clpm_pkg::UM_LSB], ev_src) : 9'h000; // R2
			assign cif[g].inc   = cnt_inc[g];
			assign cif[g].wr_lo = wr_req && hit_lo[g];
			assign cif[g].wr_hi = wr_req && hit_hi[g];
			assign cif[g].wdata = hit_lo[g] ? merge_lanes(cif[g].value[31:0], wb_dat_i, wb_sel_i)
				: merge_lanes({16'h0, cif[g].value[47:32]}, wb_dat_i, wb_sel_i);
			assign rd_lo[g]  = cif[g].value[31:0];
			assign rd_hi[g]  = {16'h0, cif[g].value[47:32]};
			assign rd_ctl[g] = ctl_reg[g];

			clpm_counter u_ctr ( // R1
				.clock  (clock),
				.resetn (resetn),
				.port   (cif[g])
			);

			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
					ctl_reg[g] <= clpm_pkg::CTL_RST;
				else if (wr_req && hit_ctl[g])
					ctl_reg[g] <= merge_lanes(ctl_reg[g], wb_dat_i, wb_sel_i); // R1
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// companion registers
	// ------------------------------------------------------------
	// software write takes the cycle; otherwise hardware counts
	assign idle_next = (wr_req && hit_idle) ? merge_lanes(idle_reg, wb_dat_i, wb_sel_i)
		: idle_reg + {31'h0, rx_idle}; // R6 R8
	assign retry_next = (wr_req && hit_retry) ? merge_lanes(retry_reg, wb_dat_i, wb_sel_i)
		: retry_reg + {31'h0, rx_retry}; // R7 R8

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rate_reg  <= clpm_pkg::RATE_RST; // R4
			idle_reg  <= 32'h0000_0000; // R8
			retry_reg <= 32'h0000_0000; // R8
		end
		else
		begin
			rate_reg  <= link_rate_code; // R4
			idle_reg  <= idle_next;
			retry_reg <= retry_next;
		end
	end

	// ------------------------------------------------------------
	// read mux and answer
	// ------------------------------------------------------------
	logic [31:0] ctr_rd;
	always_comb
	begin
		ctr_rd = 32'h0000_0000;
		for (int i = 0; i < NUM_CTR; i++)
		begin
			if (hit_lo[i])
				ctr_rd = rd_lo[i];
			if (hit_hi[i])
				ctr_rd = rd_hi[i];
			if (hit_ctl[i])
				ctr_rd = rd_ctl[i];
		end
	end

	// reserved rate bits read zero whatever was written
	assign rd_mux = hit_rate ? {29'h0, rate_reg} // R5
		: hit_idle ? idle_reg
		: hit_retry ? retry_reg
		: ctr_rd;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i)
				wb_dat_o <= rd_mux;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	AST_ACK_NEXT: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("request not answered in one cycle");

	AST_RATE_READ: assert property ((bus_req && !wb_we_i && hit_rate) // R4
		|=> wb_dat_o[31:3] == 29'h0
		&& wb_dat_o[2:0] == ($past(resetn, 2) ? $past(link_rate_code, 2) : clpm_pkg::RATE_RST))
		else $error("rate read does not mirror rate input");

	AST_IDLE_INC: assert property ((rx_idle && !(wr_req && hit_idle)) // R6
		|=> idle_reg == $past(idle_reg) + 32'h1)
		else $error("idle counter missed a cycle");

	AST_RETRY_HOLD: assert property ((!rx_retry && !(wr_req && hit_retry)) // R7
		|=> $stable(retry_reg))
		else $error("retry counter moved without retry");

	AST_RETRY_INC: assert property ((rx_retry && !(wr_req && hit_retry)) // R7
		|=> retry_reg == $past(retry_reg) + 32'h1)
		else $error("retry counter missed a cycle");

	AST_CLOCK_EVENT: assert property ((ctl_reg[0][clpm_pkg::EN_BIT] // R9
		&& ctl_reg[0][clpm_pkg::EV_MSB:clpm_pkg::EV_LSB] == clpm_pkg::EV_CLOCK
		&& !(wr_req && (hit_lo[0] || hit_hi[0] || hit_ctl[0])))
		|=> cif[0].value == $past(cif[0].value) + 48'h1)
		else $error("clock event did not add one");

	AST_DIRECT_CAND: assert property ((ctl_reg[0][clpm_pkg::EV_MSB:clpm_pkg::EV_LSB] // R17
		== clpm_pkg::EV_DIRECT && !drs_candidate) |-> cnt_inc[0] == 9'h000)
		else $error("non-candidate packet counted");

	AST_ACK_AFTER_REQ: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");

	AST_RATE_RESET: assert property (!$past(resetn) |-> rate_reg == clpm_pkg::RATE_RST) // R4
		else $error("rate register left reset with wrong value");

	AST_RATE_MIRROR: assert property ($past(resetn) |-> rate_reg == $past(link_rate_code)) // R4
		else $error("rate register does not follow rate input");

	AST_IDLE_HOLD: assert property ((!rx_idle && !(wr_req && hit_idle)) // R6
		|=> $stable(idle_reg))
		else $error("idle counter moved while receive was busy");

	AST_IDLE_WRITE: assert property ((wr_req && hit_idle && wb_sel_i == 4'hF) // R8
		|=> idle_reg == $past(wb_dat_i))
		else $error("idle counter write lost");

	AST_RETRY_WRITE: assert property ((wr_req && hit_retry && wb_sel_i == 4'hF) // R8
		|=> retry_reg == $past(wb_dat_i))
		else $error("retry counter write lost");

	AST_CTR_OFF: assert property (!ctl_reg[1][clpm_pkg::EN_BIT] |-> cnt_inc[1] == 9'h000) // R1
		else $error("disabled counter still counting");

	AST_INIT_EVENT: assert property ((ctl_reg[1][clpm_pkg::EN_BIT] // R10
		&& ctl_reg[1][clpm_pkg::EV_MSB:clpm_pkg::EV_LSB] == clpm_pkg::EV_INIT
		&& (phy_state == clpm_pkg::PHY_INIT || phy_state == clpm_pkg::PHY_FULL))
		|-> cnt_inc[1] == {8'h00, phy_state == clpm_pkg::PHY_INIT})
		else $error("initialization cycles miscounted");

	AST_SHUT_EVENT: assert property ((ctl_reg[2][clpm_pkg::EN_BIT] // R11
		&& ctl_reg[2][clpm_pkg::EV_MSB:clpm_pkg::EV_LSB] == clpm_pkg::EV_SHUT_CYC)
		|-> cnt_inc[2] == {8'h00, phy_state == clpm_pkg::PHY_SHUTDOWN})
		else $error("shutdown cycles miscounted");

	AST_OCC_EVENT: assert property ((ctl_reg[3][clpm_pkg::EN_BIT] // R3 R12
		&& ctl_reg[3][clpm_pkg::EV_MSB:clpm_pkg::EV_LSB] == clpm_pkg::EV_RX_OCC)
		|-> cnt_inc[3] == rx_occupancy)
		else $error("occupancy not added in full");

	AST_RX_HDR: assert property ((ctl_reg[1][clpm_pkg::EN_BIT] // R14 R19
		&& ctl_reg[1][clpm_pkg::EV_MSB:clpm_pkg::EV_LSB] == clpm_pkg::EV_RX_HDR)
		|-> cnt_inc[1] == {7'h00, rx_hdr_match_cnt})
		else $error("receive header matches miscounted");

	AST_TX_HDR: assert property ((ctl_reg[2][clpm_pkg::EN_BIT] // R14 R19
		&& ctl_reg[2][clpm_pkg::EV_MSB:clpm_pkg::EV_LSB] == clpm_pkg::EV_TX_HDR)
		|-> cnt_inc[2] == {7'h00, tx_hdr_match_cnt})
		else $error("transmit header matches miscounted");

	AST_DIRECT_MASK: assert property ((ctl_reg[3][clpm_pkg::EN_BIT] // R16
		&& ctl_reg[3][clpm_pkg::EV_MSB:clpm_pkg::EV_LSB] == clpm_pkg::EV_DIRECT && drs_candidate)
		|-> cnt_inc[3] == {8'h00, ctl_reg[3][clpm_pkg::UM_LSB + drs_outcome]})
		else $error("direct attempt filter ignored");
endmodule : clpm_top
`default_nettype wire

// file: sim/test_clpm_top.sv
`default_nettype none
module test_clpm_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// signals, model state and counters
	// ------------------------------------------------------------
	logic        clock    = 1'b0;
	logic        resetn   = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i  = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic        wb_ack_o;
	logic [31:0] wb_dat_o;
	logic [2:0]  link_rate_code = 3'h0, phy_state = 3'h0;
	logic        rx_idle = 1'b0, rx_retry = 1'b0, shutdown_accept_event = 1'b0, shutdown_refuse_event = 1'b0;
	logic [1:0]  rx_alloc_cnt = 2'h0, rx_bypass_cnt = 2'h0, rx_hdr_match_cnt = 2'h0, tx_hdr_match_cnt = 2'h0;
	logic [8:0]  rx_occupancy = 9'h000, credit_backlog = 9'h000;
	logic        drs_valid = 1'b0, drs_to_caching_agent = 1'b0;
	logic [1:0]  drs_outcome = 2'h0;
	logic [47:0] m_ctr [4];
	logic [31:0] m_ctl [4];
	logic [31:0] m_idle, m_retry, ra, rb, rq;
	logic [2:0]  m_rate;
	logic        tk, tw;
	logic        run = 1'b0;
	logic [31:0] exp_q [$];
	logic [15:0] evt [16] = '{16'h0001, 16'h0020, 16'h0021, 16'h0022, 16'h0023, 16'h0030, 16'h0031, 16'h0032,
		16'h0044, 16'h0005, 16'h0004, 16'h0112, 16'h0212, 16'h0412, 16'h0812, 16'h0077};
	int          n_errors   = 0;
	int          num_checks = 0;
	int          cycles     = 0;

	clpm_top #(.NUM_CTR(4)) i_clpm_top (
		.clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
		.link_rate_code(link_rate_code), .phy_state(phy_state), .rx_idle(rx_idle), .rx_retry(rx_retry),
		.shutdown_accept_event(shutdown_accept_event), .shutdown_refuse_event(shutdown_refuse_event),
		.rx_alloc_cnt(rx_alloc_cnt), .rx_bypass_cnt(rx_bypass_cnt), .rx_occupancy(rx_occupancy),
		.credit_backlog(credit_backlog), .rx_hdr_match_cnt(rx_hdr_match_cnt), .tx_hdr_match_cnt(tx_hdr_match_cnt),
		.drs_valid(drs_valid), .drs_to_caching_agent(drs_to_caching_agent), .drs_outcome(drs_outcome)
	);

	always #20 clock = ~clock;

	// ------------------------------------------------------------
	// reference model of the register file and counters
	// ------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] sl);
		for (int b = 0; b < 4; b++)
			if (sl[b])
				o[8 * b +: 8] = d[8 * b +: 8];
		return o;
	endfunction : merge

	function automatic logic [8:0] ev_inc(input logic [31:0] c);
		if (!c[22])
			return 9'h000;
		case (c[7:0])
			8'h01: return 9'h001;
			8'h20: return 9'(phy_state == 3'h0 || phy_state > 3'h4);
			8'h21: return 9'(phy_state == 3'h4);
			8'h22: return 9'(shutdown_accept_event);
			8'h23: return 9'(shutdown_refuse_event);
			8'h30: return 9'(rx_alloc_cnt);
			8'h31: return 9'(rx_bypass_cnt);
			8'h32: return rx_occupancy;
			8'h44: return credit_backlog;
			8'h05: return 9'(rx_hdr_match_cnt);
			8'h04: return 9'(tx_hdr_match_cnt);
			8'h12: return 9'(drs_valid && drs_to_caching_agent && c[8 + drs_outcome]);
			default: return 9'h000;
		endcase
	endfunction : ev_inc

	function automatic logic [31:0] rd_model(input logic [7:0] a);
		rd_model = 32'h0000_0000;
		for (int i = 0; i < 4; i++)
		begin
			if (a == 8'(8 * i))
				rd_model = m_ctr[i][31:0];
			if (a == 8'(8 * i + 4))
				rd_model = {16'h0000, m_ctr[i][47:32]};
			if (a == 8'(32 + 4 * i))
				rd_model = m_ctl[i];
		end
		if (a == 8'h30)
			rd_model = {29'h0, m_rate};
		if (a == 8'h34)
			rd_model = m_idle;
		if (a == 8'h38)
			rd_model = m_retry;
	endfunction : rd_model

	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < 4; i++)
			begin
				m_ctr[i] = 48'h0;
				m_ctl[i] = 32'h0;
			end
			m_idle = 32'h0;
			m_retry = 32'h0;
			m_rate = 3'h3;
			exp_q.delete();
		end
		else
		begin
			tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
			tw = tk && wb_we_i;
			if (tk && !wb_we_i)
				exp_q.push_back(rd_model(wb_adr_i));
			for (int i = 0; i < 4; i++)
			begin
				if (tw && wb_adr_i == 8'(8 * i))
					m_ctr[i][31:0] = merge(m_ctr[i][31:0], wb_dat_i, wb_sel_i);
				else if (tw && wb_adr_i == 8'(8 * i + 4))
					m_ctr[i][47:32] = 16'(merge({16'h0, m_ctr[i][47:32]}, wb_dat_i, wb_sel_i));
				else
					m_ctr[i] = m_ctr[i] + 48'(ev_inc(m_ctl[i]));
				if (tw && wb_adr_i == 8'(32 + 4 * i))
					m_ctl[i] = merge(m_ctl[i], wb_dat_i, wb_sel_i);
			end
			m_idle = (tw && wb_adr_i == 8'h34) ? merge(m_idle, wb_dat_i, wb_sel_i) : m_idle + 32'(rx_idle);
			m_retry = (tw && wb_adr_i == 8'h38) ? merge(m_retry, wb_dat_i, wb_sel_i) : m_retry + 32'(rx_retry);
			m_rate = link_rate_code;
		end
	end

	// ------------------------------------------------------------
	// stimulus, bus tasks and run control
	// ------------------------------------------------------------
	always @(posedge clock)
	begin
		if (run)
		begin
			ra = $urandom;
			rb = $urandom;
			link_rate_code <= ra[2:0];
			phy_state <= ra[5:3];
			{rx_idle, rx_retry, shutdown_accept_event, shutdown_refuse_event} <= ra[9:6];
			{rx_alloc_cnt, rx_bypass_cnt, rx_hdr_match_cnt, tx_hdr_match_cnt} <= ra[17:10];
			{drs_valid, drs_to_caching_agent, drs_outcome} <= ra[21:18];
			rx_occupancy <= rb[8:0];
			credit_backlog <= rb[17:9];
		end
		cycles++;
		if (cycles == 6000)
		begin
			n_errors++;
			$display("ERROR %0t: run timed out", $time);
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %0t: read %h expected %h", $time, seen, exp);
		end
	endtask : check

	// request is raised at the current edge and released at the edge that samples ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] sl,
		output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= sl;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1)
		begin
			n_errors++;
			$display("ERROR %0t: no ack at %h", $time, a);
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clock);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] sl);
		logic [31:0] q;
		bus(1'b1, a, d, sl, q);
	endtask : wr

	task automatic read_all();
		logic [31:0] q;
		for (int a = 0; a < 68; a += 4)
		begin
			bus(1'b0, (a == 64) ? 8'hFC : 8'(a), 32'h0, 4'hF, q);
			check(q, exp_q.pop_front());
		end
	endtask : read_all

	initial
	begin
		ra = $urandom(63);
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		read_all();
		$display("test reset values done");
		run <= 1'b1;
		for (int k = 0; k < 16; k++)
		begin
			wr(8'(32 + 4 * (k % 4)), {16'h0040, evt[k]}, 4'hF);
			repeat (40) @(posedge clock);
			read_all();
		end
		$display("test event selection done");
		wr(8'h20, 32'h0040_0001, 4'hF);
		wr(8'h04, 32'h0000_FFFF, 4'h3);
		wr(8'h00, 32'hFFFF_FFF0, 4'hF);
		repeat (30) @(posedge clock);
		read_all();
		$display("test counter wrap done");
		wr(8'h34, $urandom, 4'($urandom));
		wr(8'h38, $urandom, 4'($urandom));
		wr(8'h0C, $urandom, 4'hC);
		repeat (30) @(posedge clock);
		read_all();
		$display("test free counters done");
		wr(8'h30, {29'h0, 3'h5}, 4'hF);
		wr(8'h40, $urandom, 4'hF);
		wr(8'h3C, $urandom, 4'hF);
		read_all();
		$display("test rate and unmapped done");
		resetn <= 1'b0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		bus(1'b0, 8'h30, 32'h0, 4'hF, rq);
		check(rq, exp_q.pop_front());
		wr(8'h34, $urandom, 4'hF);
		wr(8'h38, $urandom, 4'hF);
		read_all();
		$display("test reset in mid-run done");
		summarize();
	end
endmodule : test_clpm_top
`default_nettype wire
